// ---- hdl/abf_pkg.sv ----
// package: register map, reset values, rate tables and shared helpers of the bit/frame clock block
package abf_pkg;

	// ********************************************************
	// clock
	// ********************************************************
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int          PHASE_W = 32;

	// ********************************************************
	// register indices (byte address = index * 4)
	// ********************************************************
	localparam logic [11:0] ABF_IDX_IF2_BIT_CLOCK_RATE = 12'h540;
	localparam logic [11:0] ABF_IDX_IF2_FRAME_DIVIDER  = 12'h546;
	localparam logic [11:0] ABF_IDX_IF2_CHANNEL_ENABLE = 12'h548;
	localparam logic [11:0] ABF_IDX_IF2_RATE_SELECT    = 12'h549;
	localparam logic [11:0] ABF_IDX_IF3_BIT_CLOCK_RATE = 12'h580;
	localparam logic [11:0] ABF_IDX_IF3_FRAME_DIVIDER  = 12'h586;
	localparam logic [11:0] ABF_IDX_IF3_CHANNEL_ENABLE = 12'h588;
	localparam logic [11:0] ABF_IDX_IF3_RATE_SELECT    = 12'h589;
	localparam logic [11:0] ABF_IDX_SYS_SAMPLE_RATES   = 12'h5c0;
	localparam logic [11:0] ABF_IDX_ASYNC_SAMPLE_RATES = 12'h5c1;
	localparam logic [11:0] ABF_IDX_STATUS             = 12'h5c2;

	// ********************************************************
	// reset values and field layout
	// ********************************************************
	localparam logic [4:0]  ABF_RATE_CODE_RESET  = 5'h0c;
	localparam logic [12:0] ABF_FRAME_DIV_RESET  = 13'h0040;
	localparam logic [4:0]  ABF_CODE_MIN_VALID   = 5'h02;
	localparam logic [4:0]  ABF_CODE_MAX_VALID   = 5'h12;
	localparam logic [4:0]  ABF_CODE_12M288      = 5'h11;
	localparam logic [3:0]  ABF_SEL_ASYNC_BASE   = 4'h8;
	localparam logic [1:0]  ABF_FAMILY_441_PREFIX = 2'h1;
	localparam int          ABF_RATE_FIELD_W     = 5;
	localparam int          ABF_RATE1_LSB        = 0;
	localparam int          ABF_RATE2_LSB        = 5;
	localparam int          ABF_RATE3_LSB        = 10;

	// ********************************************************
	// bit clock ladders in Hz, index = code - 2
	// ********************************************************
	localparam int unsigned ABF_FREQ_48K [0:16] = '{
		64_000, 96_000, 128_000, 192_000, 256_000, 384_000, 512_000, 768_000,
		1_024_000, 1_536_000, 2_048_000, 3_072_000, 4_096_000, 6_144_000,
		8_192_000, 12_288_000, 24_576_000};
	localparam int unsigned ABF_FREQ_441 [0:16] = '{
		58_800, 88_200, 117_600, 176_400, 235_200, 352_800, 470_400, 705_600,
		940_800, 1_411_200, 1_881_600, 2_882_400, 3_763_200, 5_644_800,
		7_526_400, 11_289_600, 22_579_200};

	typedef enum logic [1:0] {
		ABF_BUS_IDLE   = 2'b01,
		ABF_BUS_ANSWER = 2'b10
	} abf_bus_state_t;

	// accumulator step that overflows twice per bit clock period
	function automatic logic [PHASE_W-1:0] abf_hz_to_step(input int unsigned hz);
		logic [63:0] num;
		num = 64'(hz) << 33;
		return PHASE_W'(num / 64'(CLK_HZ));
	endfunction

	function automatic logic [PHASE_W-1:0] abf_phase_step(input logic [4:0] code,
		input logic fam_441);
		logic [4:0] idx;
		idx = 5'(code - ABF_CODE_MIN_VALID);
		if (code < ABF_CODE_MIN_VALID || code > ABF_CODE_MAX_VALID) begin
			return '0;
		end
		return fam_441 ? abf_hz_to_step(ABF_FREQ_441[idx]) : abf_hz_to_step(ABF_FREQ_48K[idx]);
	endfunction

endpackage

// ---- hdl/abf_clock_gen.sv ----
// module: one interface's bit clock and frame clock generator
`timescale 1ns/1ns
module abf_clock_gen (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [4:0]  rate_code,
	input  wire logic        family_441,
	input  wire logic [12:0] cycles_per_frame,
	output logic             bit_clock,
	output logic             frame_clock
);
	import abf_pkg::*;

	logic [PHASE_W-1:0] step;
	logic [PHASE_W-1:0] phase;
	logic [12:0]        frame_count;
	logic [PHASE_W-1:0] next_step;
	logic [PHASE_W-1:0] next_phase;
	logic               next_bit_clock;
	logic [12:0]        next_frame_count;
	logic               next_frame_clock;
	logic               quiet;

	assign quiet = (step == '0);

	// ********************************************************
	// accumulator and frame counter
	// ********************************************************
	// fractional divider: edges jitter by one clk, average rate exact to the step
	always_comb begin
		logic [PHASE_W:0] sum;
		sum = {1'b0, phase} + {1'b0, step};
		next_step = abf_phase_step(rate_code, family_441);
		next_phase = sum[PHASE_W-1:0];
		next_bit_clock = bit_clock;
		next_frame_count = frame_count;
		next_frame_clock = frame_clock;
		if (quiet) begin
			// reserved code: both clocks parked low
			next_phase = '0;
			next_bit_clock = 1'b0;
			next_frame_count = '0;
			next_frame_clock = 1'b0;
		end else if (sum[PHASE_W]) begin
			next_bit_clock = ~bit_clock;
			if (bit_clock) begin
				// frame advances on falling bit clock edges
				if (cycles_per_frame == '0) begin
					next_frame_count = '0;
					next_frame_clock = 1'b0;
				end else begin
					if (frame_count >= cycles_per_frame - 13'h0001) begin
						next_frame_count = '0;
					end else begin
						next_frame_count = frame_count + 13'h0001;
					end
					next_frame_clock = (next_frame_count < (cycles_per_frame >> 1));
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			step <= '0;
			phase <= '0;
			bit_clock <= 1'b0;
			frame_count <= '0;
			frame_clock <= 1'b0;
		end else begin
			step <= next_step;
			phase <= next_phase;
			bit_clock <= next_bit_clock;
			frame_count <= next_frame_count;
			frame_clock <= next_frame_clock;
		end
	end

	// ********************************************************
	// assertions
	// ********************************************************
	sequence s_reserved;
		rate_code < ABF_CODE_MIN_VALID;
	endsequence

	property p_reserved_quiet;
		@(posedge clk) disable iff (!nrst)
		s_reserved ##1 s_reserved |-> ##1 (!bit_clock && !frame_clock);
	endproperty
	a_reserved_quiet: assert property (p_reserved_quiet)
		else $error("bit or frame clock active under a reserved rate code");

	property p_top_rate;
		@(posedge clk) disable iff (!nrst)
		(rate_code == ABF_CODE_MAX_VALID && !family_441) |=> (step == abf_hz_to_step(ABF_FREQ_48K[16]));
	endproperty
	a_top_rate: assert property (p_top_rate)
		else $error("highest code does not give 24.576 MHz step");

	property p_alt_rate;
		@(posedge clk) disable iff (!nrst)
		(rate_code == ABF_CODE_12M288 && family_441) |=> (step == abf_hz_to_step(ABF_FREQ_441[15]));
	endproperty
	a_alt_rate: assert property (p_alt_rate)
		else $error("12.288 MHz code in 44.1k family does not give 11.2896 MHz step");

	property p_frame_on_falling;
		@(posedge clk) disable iff (!nrst)
		$changed(frame_clock) |-> ($fell(bit_clock) || $past(quiet));
	endproperty
	a_frame_on_falling: assert property (p_frame_on_falling)
		else $error("frame clock moved away from a falling bit clock edge");

endmodule // abf_clock_gen

// ---- hdl/abf_clock_ctrl.sv ----
// module: APB register file and clock generators for the second and third audio interfaces
`timescale 1ns/1ns
// Behaviour
// - five-bit rate code picks a bit clock from 64 kHz up to 24.576 MHz.
// - 44.1 kHz family swaps each code for its lower alternative frequency.
// - selector below 1000 uses system domain; family from chosen system rate field.
// - selector 1000 or above uses async domain; family from async rate field.
// - rate code writes are ignored while any channel of that interface is on.
// - frame clock equals bit clock divided by thirteen-bit cycles-per-frame count.
// - reset gives rate code 01100 and cycles-per-frame 0040h.
// - third interface has its own independent rate code and frame divider.
module abf_clock_ctrl (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             if2_bit_clock,
	output logic             if2_frame_clock,
	output logic             if3_bit_clock,
	output logic             if3_frame_clock
);
	import abf_pkg::*;

	abf_bus_state_t state;
	abf_bus_state_t next_state;
	logic [31:0]    next_prdata;
	logic           next_pready;
	logic           next_pslverr;
	logic [4:0]     if2_bitclk_rate_code;
	logic [12:0]    if2_cycles_per_frame;
	logic [7:0]     if2_channel_enable;
	logic [3:0]     if2_rate_selector;
	logic [4:0]     if3_bitclk_rate_code;
	logic [12:0]    if3_cycles_per_frame;
	logic [7:0]     if3_channel_enable;
	logic [3:0]     if3_rate_selector;
	logic [14:0]    sys_sample_rates;
	logic [9:0]     async_sample_rates;
	logic           if2_family_441;
	logic           if3_family_441;
	logic [4:0]     next_if2_bitclk_rate_code;
	logic [12:0]    next_if2_cycles_per_frame;
	logic [7:0]     next_if2_channel_enable;
	logic [3:0]     next_if2_rate_selector;
	logic [4:0]     next_if3_bitclk_rate_code;
	logic [12:0]    next_if3_cycles_per_frame;
	logic [7:0]     next_if3_channel_enable;
	logic [3:0]     next_if3_rate_selector;
	logic [14:0]    next_sys_sample_rates;
	logic [9:0]     next_async_sample_rates;
	logic           next_if2_family_441;
	logic           next_if3_family_441;
	logic           if2_locked;
	logic           if3_locked;
	logic           rd_hit;
	logic [31:0]    rd_value;
	logic           commit;
	logic [15:0]    wr_word;

	// ********************************************************
	// helpers
	// ********************************************************
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = wd[7:0];
		end
		if (strb[1]) begin
			res[15:8] = wd[15:8];
		end
		return res;
	endfunction

	// selector 0..2 picks system field 1..3, 8..9 picks async field 1..2
	function automatic logic pick_family(input logic [3:0] sel, input logic [14:0] sys,
		input logic [9:0] asy);
		logic [4:0] field;
		field = sys[ABF_RATE1_LSB +: ABF_RATE_FIELD_W];
		if (sel < ABF_SEL_ASYNC_BASE) begin
			if (sel == 4'h1) begin
				field = sys[ABF_RATE2_LSB +: ABF_RATE_FIELD_W];
			end else if (sel == 4'h2) begin
				field = sys[ABF_RATE3_LSB +: ABF_RATE_FIELD_W];
			end
		end else begin
			field = asy[ABF_RATE1_LSB +: ABF_RATE_FIELD_W];
			if (sel == 4'h9) begin
				field = asy[ABF_RATE2_LSB +: ABF_RATE_FIELD_W];
			end
		end
		return field[4:3] == ABF_FAMILY_441_PREFIX;
	endfunction

	assign if2_locked = (if2_channel_enable != 8'h00);
	assign if3_locked = (if3_channel_enable != 8'h00);

	// ********************************************************
	// read decode
	// ********************************************************
	always_comb begin
		rd_hit = 1'b1;
		rd_value = 32'h0000_0000;
		if (paddr[15:14] != 2'h0 || paddr[1:0] != 2'h0) begin
			rd_hit = 1'b0;
		end else begin
			case (paddr[13:2])
				ABF_IDX_IF2_BIT_CLOCK_RATE: rd_value = {27'h0, if2_bitclk_rate_code};
				ABF_IDX_IF2_FRAME_DIVIDER:  rd_value = {19'h0, if2_cycles_per_frame};
				ABF_IDX_IF2_CHANNEL_ENABLE: rd_value = {24'h0, if2_channel_enable};
				ABF_IDX_IF2_RATE_SELECT:    rd_value = {28'h0, if2_rate_selector};
				ABF_IDX_IF3_BIT_CLOCK_RATE: rd_value = {27'h0, if3_bitclk_rate_code};
				ABF_IDX_IF3_FRAME_DIVIDER:  rd_value = {19'h0, if3_cycles_per_frame};
				ABF_IDX_IF3_CHANNEL_ENABLE: rd_value = {24'h0, if3_channel_enable};
				ABF_IDX_IF3_RATE_SELECT:    rd_value = {28'h0, if3_rate_selector};
				ABF_IDX_SYS_SAMPLE_RATES:   rd_value = {17'h0, sys_sample_rates};
				ABF_IDX_ASYNC_SAMPLE_RATES: rd_value = {22'h0, async_sample_rates};
				ABF_IDX_STATUS: begin
					rd_value = {28'h0, if3_family_441, if2_family_441, if3_locked, if2_locked};
				end
				default: rd_hit = 1'b0;
			endcase
		end
	end

	// ********************************************************
	// bus slave and register writes
	// ********************************************************
	// one wait-free access phase; prdata captured in the setup cycle
	always_comb begin
		next_state = state;
		next_prdata = prdata;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		commit = 1'b0;
		wr_word = 16'h0000;
		next_if2_bitclk_rate_code = if2_bitclk_rate_code;
		next_if2_cycles_per_frame = if2_cycles_per_frame;
		next_if2_channel_enable = if2_channel_enable;
		next_if2_rate_selector = if2_rate_selector;
		next_if3_bitclk_rate_code = if3_bitclk_rate_code;
		next_if3_cycles_per_frame = if3_cycles_per_frame;
		next_if3_channel_enable = if3_channel_enable;
		next_if3_rate_selector = if3_rate_selector;
		next_sys_sample_rates = sys_sample_rates;
		next_async_sample_rates = async_sample_rates;
		next_if2_family_441 = pick_family(if2_rate_selector, sys_sample_rates, async_sample_rates);
		next_if3_family_441 = pick_family(if3_rate_selector, sys_sample_rates, async_sample_rates);
		case (state)
			ABF_BUS_IDLE: begin
				if (psel && !penable) begin
					next_state = ABF_BUS_ANSWER;
					next_pready = 1'b1;
					next_pslverr = !rd_hit;
					next_prdata = (pwrite || !rd_hit) ? 32'h0000_0000 : rd_value;
				end
			end
			ABF_BUS_ANSWER: begin
				next_state = ABF_BUS_IDLE;
				commit = psel && penable && pwrite && rd_hit;
			end
			default: next_state = ABF_BUS_IDLE;
		endcase
		if (commit) begin
			case (paddr[13:2])
				ABF_IDX_IF2_BIT_CLOCK_RATE: begin
					wr_word = merge16({11'h0, if2_bitclk_rate_code}, pwdata, pstrb);
					if (!if2_locked) begin
						next_if2_bitclk_rate_code = wr_word[4:0];
					end
				end
				ABF_IDX_IF2_FRAME_DIVIDER: begin
					wr_word = merge16({3'h0, if2_cycles_per_frame}, pwdata, pstrb);
					next_if2_cycles_per_frame = wr_word[12:0];
				end
				ABF_IDX_IF2_CHANNEL_ENABLE: begin
					wr_word = merge16({8'h0, if2_channel_enable}, pwdata, pstrb);
					next_if2_channel_enable = wr_word[7:0];
				end
				ABF_IDX_IF2_RATE_SELECT: begin
					wr_word = merge16({12'h0, if2_rate_selector}, pwdata, pstrb);
					next_if2_rate_selector = wr_word[3:0];
				end
				ABF_IDX_IF3_BIT_CLOCK_RATE: begin
					wr_word = merge16({11'h0, if3_bitclk_rate_code}, pwdata, pstrb);
					if (!if3_locked) begin
						next_if3_bitclk_rate_code = wr_word[4:0];
					end
				end
				ABF_IDX_IF3_FRAME_DIVIDER: begin
					wr_word = merge16({3'h0, if3_cycles_per_frame}, pwdata, pstrb);
					next_if3_cycles_per_frame = wr_word[12:0];
				end
				ABF_IDX_IF3_CHANNEL_ENABLE: begin
					wr_word = merge16({8'h0, if3_channel_enable}, pwdata, pstrb);
					next_if3_channel_enable = wr_word[7:0];
				end
				ABF_IDX_IF3_RATE_SELECT: begin
					wr_word = merge16({12'h0, if3_rate_selector}, pwdata, pstrb);
					next_if3_rate_selector = wr_word[3:0];
				end
				ABF_IDX_SYS_SAMPLE_RATES: begin
					wr_word = merge16({1'b0, sys_sample_rates}, pwdata, pstrb);
					next_sys_sample_rates = wr_word[14:0];
				end
				ABF_IDX_ASYNC_SAMPLE_RATES: begin
					wr_word = merge16({6'h0, async_sample_rates}, pwdata, pstrb);
					next_async_sample_rates = wr_word[9:0];
				end
				default: wr_word = 16'h0000; // status is read-only
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= ABF_BUS_IDLE;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			if2_bitclk_rate_code <= ABF_RATE_CODE_RESET;
			if2_cycles_per_frame <= ABF_FRAME_DIV_RESET;
			if2_channel_enable <= 8'h00;
			if2_rate_selector <= 4'h0;
			if3_bitclk_rate_code <= ABF_RATE_CODE_RESET;
			if3_cycles_per_frame <= ABF_FRAME_DIV_RESET;
			if3_channel_enable <= 8'h00;
			if3_rate_selector <= 4'h0;
			sys_sample_rates <= 15'h0000;
			async_sample_rates <= 10'h000;
			if2_family_441 <= 1'b0;
			if3_family_441 <= 1'b0;
		end else begin
			state <= next_state;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			if2_bitclk_rate_code <= next_if2_bitclk_rate_code;
			if2_cycles_per_frame <= next_if2_cycles_per_frame;
			if2_channel_enable <= next_if2_channel_enable;
			if2_rate_selector <= next_if2_rate_selector;
			if3_bitclk_rate_code <= next_if3_bitclk_rate_code;
			if3_cycles_per_frame <= next_if3_cycles_per_frame;
			if3_channel_enable <= next_if3_channel_enable;
			if3_rate_selector <= next_if3_rate_selector;
			sys_sample_rates <= next_sys_sample_rates;
			async_sample_rates <= next_async_sample_rates;
			if2_family_441 <= next_if2_family_441;
			if3_family_441 <= next_if3_family_441;
		end
	end

	// ********************************************************
	// generators, one per interface
	// ********************************************************
	abf_clock_gen u_if2_gen (
		.clk              (clk),
		.nrst             (nrst),
		.rate_code        (if2_bitclk_rate_code),
		.family_441       (if2_family_441),
		.cycles_per_frame (if2_cycles_per_frame),
		.bit_clock        (if2_bit_clock),
		.frame_clock      (if2_frame_clock)
	);

	// separate instance, so locking and timing never couple the two
	abf_clock_gen u_if3_gen (
		.clk              (clk),
		.nrst             (nrst),
		.rate_code        (if3_bitclk_rate_code),
		.family_441       (if3_family_441),
		.cycles_per_frame (if3_cycles_per_frame),
		.bit_clock        (if3_bit_clock),
		.frame_clock      (if3_frame_clock)
	);

	// ********************************************************
	// assertions
	// ********************************************************
	sequence s_if2_rate_write;
		commit && paddr[13:2] == ABF_IDX_IF2_BIT_CLOCK_RATE && pstrb[0];
	endsequence

	sequence s_if3_rate_write;
		commit && paddr[13:2] == ABF_IDX_IF3_BIT_CLOCK_RATE && pstrb[0];
	endsequence

	property p_lock_hold;
		@(posedge clk) disable iff (!nrst)
		(s_if2_rate_write and if2_locked) |=> $stable(if2_bitclk_rate_code);
	endproperty
	a_lock_hold: assert property (p_lock_hold)
		else $error("rate code changed while channels enabled");

	property p_unlocked_write;
		@(posedge clk) disable iff (!nrst)
		(s_if2_rate_write and !if2_locked) |=> (if2_bitclk_rate_code == $past(pwdata[4:0]));
	endproperty
	a_unlocked_write: assert property (p_unlocked_write)
		else $error("rate code write lost with all channels disabled");

	property p_if3_independent;
		@(posedge clk) disable iff (!nrst)
		(s_if3_rate_write and (!if3_locked && if2_locked))
			|=> (if3_bitclk_rate_code == $past(pwdata[4:0]));
	endproperty
	a_if3_independent: assert property (p_if3_independent)
		else $error("third interface write blocked by second interface channels");

	property p_reset_values;
		@(posedge clk)
		!nrst |=> (if2_bitclk_rate_code == ABF_RATE_CODE_RESET
			&& if2_cycles_per_frame == ABF_FRAME_DIV_RESET
			&& if3_bitclk_rate_code == ABF_RATE_CODE_RESET
			&& if3_cycles_per_frame == ABF_FRAME_DIV_RESET);
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("rate code or frame divider wrong after reset");

	property p_family_sys;
		@(posedge clk) disable iff (!nrst)
		(if2_rate_selector == 4'h0) |=>
			(if2_family_441 == ($past(sys_sample_rates[4:3]) == ABF_FAMILY_441_PREFIX));
	endproperty
	a_family_sys: assert property (p_family_sys)
		else $error("system domain family does not follow system rate field");

	property p_family_async;
		@(posedge clk) disable iff (!nrst)
		(if2_rate_selector == ABF_SEL_ASYNC_BASE) |=>
			(if2_family_441 == ($past(async_sample_rates[4:3]) == ABF_FAMILY_441_PREFIX));
	endproperty
	a_family_async: assert property (p_family_async)
		else $error("async domain family does not follow async rate field");

	property p_bus_answer;
		@(posedge clk) disable iff (!nrst)
		(state == ABF_BUS_IDLE && psel && !penable) |=> pready ##1 !pready;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("bus answer not exactly one cycle after setup");

endmodule // abf_clock_ctrl

// ---- dv/abf_far_end.sv ----
// far-side codec model: counts bit clocks per frame and in total
`timescale 1ns/1ns
module abf_far_end (
	input wire logic clk,
	input wire logic bit_clock,
	input wire logic frame_clock
);
	int   bits_in_frame = 0;
	int   frame_bits    = 0;
	int   bit_rises     = 0;
	logic last_bit      = 1'b0;
	logic last_frame    = 1'b0;

	// sampled on the system clock, so edges within one clk period merge
	always @(posedge clk) begin
		if (bit_clock === 1'b1 && last_bit === 1'b0) begin
			bits_in_frame++;
			bit_rises++;
		end
		if (frame_clock === 1'b1 && last_frame === 1'b0) begin
			frame_bits = bits_in_frame;
			bits_in_frame = 0;
		end
		last_bit = bit_clock;
		last_frame = frame_clock;
	end
endmodule // abf_far_end

// ---- dv/testbench.sv ----
// self-checking bench for the bit and frame clock control block
`timescale 1ns/1ns
module testbench;
	import abf_pkg::*;
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, err, b2, f2, b3, f3;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd, hi;
	logic [3:0]  pstrb;
	int          num_errors, samples_checked, n, r0, fn;
	int          mdl [int];

	abf_clock_ctrl i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .if2_bit_clock(b2), .if2_frame_clock(f2),
		.if3_bit_clock(b3), .if3_frame_clock(f3));
	abf_far_end i_far2 (.clk(clk), .bit_clock(b2), .frame_clock(f2));
	abf_far_end i_far3 (.clk(clk), .bit_clock(b3), .frame_clock(f3));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task end_sim;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp, input int tol);
		samples_checked++;
		if (((seen + tol >= exp) && (seen <= exp + tol)) !== 1'b1) begin
			num_errors++;
			$display("BAD %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	function automatic logic [31:0] wmask(input int idx);
		case (idx)
			ABF_IDX_IF2_BIT_CLOCK_RATE, ABF_IDX_IF3_BIT_CLOCK_RATE: return 32'h1f;
			ABF_IDX_IF2_FRAME_DIVIDER, ABF_IDX_IF3_FRAME_DIVIDER: return 32'h1fff;
			ABF_IDX_IF2_CHANNEL_ENABLE, ABF_IDX_IF3_CHANNEL_ENABLE: return 32'hff;
			ABF_IDX_IF2_RATE_SELECT, ABF_IDX_IF3_RATE_SELECT: return 32'hf;
			ABF_IDX_SYS_SAMPLE_RATES: return 32'h7fff;
			ABF_IDX_ASYNC_SAMPLE_RATES: return 32'h3ff;
			default: return 32'h0;
		endcase
	endfunction

	// 44.1 kHz family when the referenced rate field reads 01xxx
	function automatic int fam(input int sel);
		logic [14:0] s;
		logic [4:0]  f;
		s = 15'(mdl[ABF_IDX_SYS_SAMPLE_RATES]);
		f = (sel == 1) ? s[9:5] : (sel == 2) ? s[14:10] : s[4:0];
		if (sel >= 8)
			f = 5'(mdl[ABF_IDX_ASYNC_SAMPLE_RATES] >> ((sel == 9) ? 5 : 0));
		return int'(f[4:3] == 2'b01);
	endfunction

	task apb(input logic w, input int idx, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= 16'(idx * 4);
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// pready, prdata and pslverr read at the edge that samples them
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			num_errors++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input int idx, input logic [31:0] v);
		apb(1'b1, idx, v);
		check("write error", {31'h0, err}, !mdl.exists(idx), 0);
		if (!mdl.exists(idx))
			return;
		if ((idx == ABF_IDX_IF2_BIT_CLOCK_RATE && mdl[ABF_IDX_IF2_CHANNEL_ENABLE] != 0) ||
			(idx == ABF_IDX_IF3_BIT_CLOCK_RATE && mdl[ABF_IDX_IF3_CHANNEL_ENABLE] != 0))
			return;
		mdl[idx] = v & wmask(idx) | mdl[idx] & ~wmask(idx);
		mdl[ABF_IDX_STATUS] = (mdl[ABF_IDX_IF2_CHANNEL_ENABLE] != 0) |
			(mdl[ABF_IDX_IF3_CHANNEL_ENABLE] != 0) << 1 |
			fam(mdl[ABF_IDX_IF2_RATE_SELECT]) << 2 | fam(mdl[ABF_IDX_IF3_RATE_SELECT]) << 3;
	endtask

	task rdc(input int idx);
		apb(1'b0, idx, 32'h0);
		check($sformatf("reg %0h", idx), rd, mdl.exists(idx) ? mdl[idx] : 0, 0);
	endtask

	task rate(input string nm, input int hz);
		r0 = i_far2.bit_rises;
		repeat (2000) @(posedge clk);
		check(nm, 32'(i_far2.bit_rises - r0), 32'(hz / 50000), 2);
	endtask

	// ********************************************************
	// main sequence
	// ********************************************************
	initial begin
		num_errors = 0;
		samples_checked = 0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		nrst = 1'b0;
		void'($urandom(96));
		for (int a = 'h540; a < 'h5c3; a++)
			if (wmask(a) != 0 || a == ABF_IDX_STATUS)
				mdl[a] = 0;
		mdl[ABF_IDX_IF2_BIT_CLOCK_RATE] = 'h0c;
		mdl[ABF_IDX_IF3_BIT_CLOCK_RATE] = 'h0c;
		mdl[ABF_IDX_IF2_FRAME_DIVIDER] = 'h40;
		mdl[ABF_IDX_IF3_FRAME_DIVIDER] = 'h40;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		foreach (mdl[k]) rdc(k);
		rdc('h541);
		fn = 2 + $urandom % 14;
		wr(ABF_IDX_IF2_FRAME_DIVIDER, fn);
		wr(ABF_IDX_IF2_BIT_CLOCK_RATE, 'h12);
		wr(ABF_IDX_IF3_FRAME_DIVIDER, 4);
		wr(ABF_IDX_IF3_BIT_CLOCK_RATE, 'h10);
		repeat (600) @(posedge clk);
		check("if2 frame", i_far2.frame_bits, fn, 0);
		check("if3 frame", i_far3.frame_bits, 4, 0);
		rate("if2 top", 24_576_000);
		wr(ABF_IDX_IF2_BIT_CLOCK_RATE, 'h11);
		rate("if2 48k", 12_288_000);
		wr(ABF_IDX_SYS_SAMPLE_RATES, 'h8);
		rate("if2 44k", 11_289_600);
		wr(ABF_IDX_IF2_RATE_SELECT, 8);
		rate("if2 async 48k", 12_288_000);
		wr(ABF_IDX_ASYNC_SAMPLE_RATES, 'h100);
		wr(ABF_IDX_IF2_RATE_SELECT, 9);
		rate("if2 async 44k", 11_289_600);
		wr(ABF_IDX_IF2_CHANNEL_ENABLE, 'h1);
		wr(ABF_IDX_IF2_BIT_CLOCK_RATE, 'h05);
		wr(ABF_IDX_IF3_BIT_CLOCK_RATE, 'h03);
		wr(ABF_IDX_STATUS, 'hf);
		foreach (mdl[k]) rdc(k);
		wr(ABF_IDX_IF2_CHANNEL_ENABLE, 'h0);
		wr(ABF_IDX_IF2_BIT_CLOCK_RATE, 'h05);
		foreach (mdl[k]) rdc(k);
		for (int c = 0; c < 2; c++) begin
			wr(ABF_IDX_IF2_BIT_CLOCK_RATE, c);
			repeat (20) @(posedge clk);
			r0 = i_far2.bit_rises;
			hi = 0;
			repeat (200) begin
				@(posedge clk);
				hi = hi + f2;
			end
			check("reserved quiet", hi + 32'(i_far2.bit_rises - r0), 0, 0);
		end
		end_sim();
	end
endmodule // testbench
